// [pblc_chk.sv]
// PRBS checker with lock, sync-loss and error counter
`timescale 1ns/1ps
`default_nettype none

module pblc_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic chk_en,
  input wire logic err_mode,
  // Received nibbles
  input wire logic [3:0] rxd,
  input wire logic rx_dv,
  // Status
  output logic locked,
  output logic loss,
  output logic err_wrap,
  output logic [7:0] err_count
);

  typedef struct packed {
    logic locked;
    logic loss;
    logic wrap;
    logic [3:0] run;
    logic [7:0] cnt;
    logic [14:0] lfsr;
  } pblc_chk_s;

  pblc_chk_s s;
  pblc_chk_s next_s;

  always_comb begin
    logic [14:0] pred;
    logic match;
    pred = pblc_pkg::pblc_prbs_step(s.lfsr);
    // An all-zero register predicts zeros forever; never lock on it
    match = (pred[3:0] == rxd) && (s.lfsr != 15'h0000);
    next_s = s;
    next_s.wrap = 1'b0;
    next_s.loss = 1'b0;
    if (!chk_en) begin
      next_s = '0;
    end else if (rx_dv && !s.locked) begin
      // Self-seeding: shift in what arrives until predictions hold
      next_s.lfsr = {s.lfsr[10:0], rxd};
      next_s.run = match ? 4'(s.run + 4'h1) : 4'h0;
      if (match && s.run == 4'(pblc_pkg::LOCK_CNT - 4'h1)) begin
        next_s.locked = 1'b1;
        next_s.run = 4'h0;
      end
    end else if (rx_dv) begin
      next_s.lfsr = pred;
      next_s.run = 4'h0;
      if (!match) begin
        next_s.run = 4'(s.run + 4'h1);
        if (s.run == 4'(pblc_pkg::LOSS_CNT - 4'h1)) begin
          next_s.locked = 1'b0;
          next_s.loss = 1'b1;
          next_s.run = 4'h0;
        end
        if (err_mode) begin
          if (s.cnt == pblc_pkg::ERR_MAX) begin
            next_s.cnt = 8'h00;
            next_s.wrap = 1'b1;
          end else begin
            next_s.cnt = 8'(s.cnt + 8'h01);
          end
        end else if (s.cnt != pblc_pkg::ERR_MAX) begin
          next_s.cnt = 8'(s.cnt + 8'h01);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign locked = s.locked;
  assign loss = s.loss;
  assign err_wrap = s.wrap;
  assign err_count = s.cnt;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_err_wrap_zero: assert property (
    err_wrap |-> (err_count == 8'h00) && ($past(err_count) == pblc_pkg::ERR_MAX))
    else $error("wrap pulse without counter returning to zero from max");

  chk_err_hold_max: assert property (
    chk_en && !err_mode && (err_count == pblc_pkg::ERR_MAX) ##1 chk_en
      |-> err_count == pblc_pkg::ERR_MAX)
    else $error("single mode counter left its maximum");

endmodule
`default_nettype wire

// [pblc_pkg.sv]
// Constants, types and helpers for the PRBS self-test and loopback control block
//
// Overview of operation
// - Continuous counter mode: at maximum, pulse and restart counting from zero
// - Single counter mode: error counter holds at maximum, no more counting
// - Packet type 1 with generator on: PRBS packets sent repeatedly, each followed by a gap
// - Packet type 1 with generator off: checker stays active on received data
// - Packet type 0 with generator on: one constant packet, PRBS gen/check off
// - Generator enable bit turns packet generator on (1) and off (0)
// - Lock flag reads 1 while checker is locked to incoming stream
// - Sync-loss flag latches high on loss of sync and stays set until a read reports it
// - Generator status reads 1 while generator is active producing packets
// - Loopback field: 0000 normal, 0001 PCS, 0010 analog, 0100 reverse
// - In MII-side loopback, line-transmit bit forwards or suppresses data to line
// - Line-transmit bit is accepted only while MII-side loopback is selected

package pblc_pkg;

  // Register index; byte address is four times it
  localparam logic [9:0] REG_IDX = 10'h016;

  // Field positions
  localparam int ERR_MODE_BIT = 14;
  localparam int PKT_TYPE_BIT = 13;
  localparam int GEN_EN_BIT = 12;
  localparam int LOCK_BIT = 11;
  localparam int SYNC_LOSS_BIT = 10;
  localparam int GEN_STAT_BIT = 9;
  localparam int FIXED_LSB = 7;
  localparam int LINE_TX_BIT = 6;
  localparam int LB_LSB = 2;
  localparam int SPARE_LSB = 0;

  // Values after reset
  localparam logic [1:0] FIXED_VAL = 2'h2;
  localparam logic [3:0] LB_RESET = 4'h0;
  localparam logic [1:0] SPARE_RESET = 2'h0;
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;

  // Loopback codes
  localparam logic [3:0] LB_NORMAL = 4'h0;
  localparam logic [3:0] LB_PCS = 4'h1;
  localparam logic [3:0] LB_ANALOG = 4'h2;
  localparam logic [3:0] LB_REVERSE = 4'h4;

  // Packet shape in nibbles, and counts of cycles
  localparam logic [7:0] PKT_NIB = 8'h40;
  localparam logic [7:0] GAP_NIB = 8'h18;
  localparam logic [3:0] CONST_NIB = 4'h5;
  localparam logic [3:0] LOCK_CNT = 4'h8;
  localparam logic [3:0] LOSS_CNT = 4'h4;
  localparam logic [7:0] ERR_MAX = 8'hFF;

  typedef enum logic [1:0] {G_IDLE, G_DATA, G_GAP, G_DONE} pblc_gen_e;

  // x^15 + x^14 + 1, four bits a cycle, newest bits land in [3:0]
  function automatic logic [14:0] pblc_prbs_step(input logic [14:0] s);
    logic [14:0] t;
    t = s;
    for (int i = 0; i < 4; i++) begin
      t = {t[13:0], t[14] ^ t[13]};
    end
    return t;
  endfunction

endpackage

// [pblc_top.sv]
// PRBS self-test, packet generator and loopback control with APB register
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pblc_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmit nibbles from the MAC side
  input wire logic [3:0] mac_txd,
  input wire logic mac_tx_en,
  // Transmit nibbles towards the line
  output logic [3:0] line_txd,
  output logic line_tx_en,
  // Received nibbles for the checker
  input wire logic [3:0] line_rxd,
  input wire logic line_rx_dv,
  // Loopback path selects
  output logic lb_pcs,
  output logic lb_analog,
  output logic lb_reverse,
  // Checker error counter
  output logic err_wrap,
  output logic [7:0] err_count
);

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic err_mode;
    logic pkt_type;
    logic gen_en;
    logic line_tx_ok;
    logic [3:0] lb;
    logic [1:0] spare;
    logic sync_loss;
    pblc_pkg::pblc_gen_e gst;
    logic [7:0] gcnt;
    logic [14:0] lfsr;
    logic [3:0] txd;
    logic tx_en;
    logic lb_pcs;
    logic lb_analog;
    logic lb_reverse;
  } pblc_top_s;

  pblc_top_s s;
  pblc_top_s next_s;

  logic chk_en;
  logic chk_locked;
  logic chk_loss;

  // Active generator owns the line; status follows it
  function automatic logic gen_busy(input pblc_pkg::pblc_gen_e g);
    return (g == pblc_pkg::G_DATA) || (g == pblc_pkg::G_GAP);
  endfunction

  // Checker runs only for PRBS packet type, generator on or off
  assign chk_en = s.pkt_type;

  pblc_chk u_chk (
    .pclk(pclk),
    .presetn(presetn),
    .chk_en(chk_en),
    .err_mode(s.err_mode),
    .rxd(line_rxd),
    .rx_dv(line_rx_dv),
    .locked(chk_locked),
    .loss(chk_loss),
    .err_wrap(err_wrap),
    .err_count(err_count)
  );

  always_comb begin
    logic setup;
    logic hit;
    logic acc;
    logic [15:0] rword;
    logic [3:0] new_lb;
    logic [14:0] step;
    setup = psel && !penable;
    hit = (paddr[11:2] == pblc_pkg::REG_IDX);
    acc = psel && penable && s.pready && !s.pslverr;
    new_lb = pwdata[pblc_pkg::LB_LSB +: 4];
    step = pblc_pkg::pblc_prbs_step(s.lfsr);
    rword = 16'h0000;
    rword[pblc_pkg::ERR_MODE_BIT] = s.err_mode;
    rword[pblc_pkg::PKT_TYPE_BIT] = s.pkt_type;
    rword[pblc_pkg::GEN_EN_BIT] = s.gen_en;
    rword[pblc_pkg::LOCK_BIT] = chk_locked;
    rword[pblc_pkg::SYNC_LOSS_BIT] = s.sync_loss;
    rword[pblc_pkg::GEN_STAT_BIT] = gen_busy(s.gst);
    rword[pblc_pkg::FIXED_LSB +: 2] = pblc_pkg::FIXED_VAL;
    rword[pblc_pkg::LINE_TX_BIT] = s.line_tx_ok;
    rword[pblc_pkg::LB_LSB +: 4] = s.lb;
    rword[pblc_pkg::SPARE_LSB +: 2] = s.spare;
    next_s = s;

    // Zero-wait slave: answer in the cycle after setup
    next_s.pready = setup;
    next_s.pslverr = setup && !hit;
    next_s.prdata = (setup && hit && !pwrite) ? {16'h0000, rword} : 32'h0000_0000;

    if (acc && pwrite) begin
      next_s.err_mode = pwdata[pblc_pkg::ERR_MODE_BIT];
      next_s.pkt_type = pwdata[pblc_pkg::PKT_TYPE_BIT];
      next_s.gen_en = pwdata[pblc_pkg::GEN_EN_BIT];
      next_s.lb = new_lb;
      next_s.spare = pwdata[pblc_pkg::SPARE_LSB +: 2];
      // Only kept when the same write selects MII-side loopback
      next_s.line_tx_ok = pwdata[pblc_pkg::LINE_TX_BIT]
                          && (new_lb == pblc_pkg::LB_PCS);
    end

    // Clear only what the read reported, so a fresh loss is not lost
    if (chk_loss) begin
      next_s.sync_loss = 1'b1;
    end else if (acc && !pwrite && s.prdata[pblc_pkg::SYNC_LOSS_BIT]) begin
      next_s.sync_loss = 1'b0;
    end

    // Reserved code 1000 and unlisted codes leave every path off
    next_s.lb_pcs = (next_s.lb == pblc_pkg::LB_PCS);
    next_s.lb_analog = (next_s.lb == pblc_pkg::LB_ANALOG);
    next_s.lb_reverse = (next_s.lb == pblc_pkg::LB_REVERSE);

    // Packet generator
    next_s.gcnt = 8'(s.gcnt + 8'h01);
    case (s.gst)
      pblc_pkg::G_IDLE: begin
        next_s.gcnt = 8'h00;
        next_s.lfsr = pblc_pkg::PRBS_SEED;
        if (s.gen_en) begin
          next_s.gst = pblc_pkg::G_DATA;
        end
      end
      pblc_pkg::G_DATA: begin
        if (s.pkt_type) begin
          next_s.lfsr = step;
        end
        if (s.gcnt == 8'(pblc_pkg::PKT_NIB - 8'h01)) begin
          next_s.gst = pblc_pkg::G_GAP;
          next_s.gcnt = 8'h00;
        end
      end
      pblc_pkg::G_GAP: begin
        if (s.gcnt == 8'(pblc_pkg::GAP_NIB - 8'h01)) begin
          next_s.gcnt = 8'h00;
          if (s.pkt_type) begin
            next_s.gst = pblc_pkg::G_DATA;
          end else begin
            next_s.gst = pblc_pkg::G_DONE;
          end
        end
      end
      pblc_pkg::G_DONE: begin
        next_s.gcnt = 8'h00;
      end
      default: begin
        next_s.gst = pblc_pkg::G_IDLE;
      end
    endcase
    if (!s.gen_en) begin
      next_s.gst = pblc_pkg::G_IDLE;
    end

    // Line transmit selection
    if (s.gst == pblc_pkg::G_DATA) begin
      next_s.txd = s.pkt_type ? step[3:0] : pblc_pkg::CONST_NIB;
      next_s.tx_en = 1'b1;
    end else if (gen_busy(s.gst)) begin
      next_s.txd = 4'h0;
      next_s.tx_en = 1'b0;
    end else if (s.lb_pcs && !s.line_tx_ok) begin
      next_s.txd = 4'h0;
      next_s.tx_en = 1'b0;
    end else begin
      next_s.txd = mac_txd;
      next_s.tx_en = mac_tx_en;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.gst <= pblc_pkg::G_IDLE;
      s.lb <= pblc_pkg::LB_RESET;
      s.spare <= pblc_pkg::SPARE_RESET;
      s.lfsr <= pblc_pkg::PRBS_SEED;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign line_txd = s.txd;
  assign line_tx_en = s.tx_en;
  assign lb_pcs = s.lb_pcs;
  assign lb_analog = s.lb_analog;
  assign lb_reverse = s.lb_reverse;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_apb_ready_next: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");

  chk_apb_unmapped: assert property (
    psel && !penable && (paddr[11:2] != pblc_pkg::REG_IDX) |=> pslverr)
    else $error("unmapped access not flagged");

  chk_cont_next_pkt: assert property (
    s.gst == pblc_pkg::G_GAP && s.gcnt == 8'(pblc_pkg::GAP_NIB - 8'h01)
      && s.pkt_type && s.gen_en |=> s.gst == pblc_pkg::G_DATA ##1 line_tx_en)
    else $error("continuous mode did not start the next packet");

  chk_checker_on: assert property (
    s.pkt_type && !s.gen_en |-> chk_en)
    else $error("checker off with PRBS type and generator off");

  chk_single_stop: assert property (
    s.gst == pblc_pkg::G_DONE && s.gen_en |=> s.gst == pblc_pkg::G_DONE)
    else $error("single packet mode sent again");

  chk_gen_off_idle: assert property (
    !s.gen_en |=> s.gst == pblc_pkg::G_IDLE)
    else $error("generator kept running while disabled");

  chk_lock_read: assert property (
    psel && !penable && !pwrite && (paddr[11:2] == pblc_pkg::REG_IDX)
      |=> prdata[pblc_pkg::LOCK_BIT] == $past(chk_locked))
    else $error("lock flag read differs from checker");

  chk_loss_latch: assert property (
    chk_loss |=> s.sync_loss)
    else $error("sync loss not latched");

  chk_gen_status: assert property (
    psel && !penable && !pwrite && (paddr[11:2] == pblc_pkg::REG_IDX)
      |=> prdata[pblc_pkg::GEN_STAT_BIT] == gen_busy($past(s.gst)))
    else $error("generator status read wrong");

  chk_lb_decode: assert property (
    (s.lb == pblc_pkg::LB_ANALOG) |-> lb_analog && !lb_pcs && !lb_reverse)
    else $error("analog loopback select wrong");

  chk_line_gate: assert property (
    s.lb_pcs && !s.line_tx_ok && !gen_busy(s.gst) |=> !line_tx_en)
    else $error("line transmit not suppressed in MII loopback");

  chk_line_ok_mode: assert property (
    s.line_tx_ok |-> s.lb == pblc_pkg::LB_PCS)
    else $error("line transmit bit held outside MII loopback");

  chk_loss_clear: assert property (
    psel && penable && pready && !pslverr && !pwrite
      && prdata[pblc_pkg::SYNC_LOSS_BIT] && !chk_loss |=> !s.sync_loss)
    else $error("sync loss not cleared by read");

  chk_lb_pcs_sel: assert property (
    (s.lb == pblc_pkg::LB_PCS) |-> lb_pcs && !lb_analog && !lb_reverse)
    else $error("PCS loopback select wrong");

  chk_lb_rev_sel: assert property (
    (s.lb == pblc_pkg::LB_REVERSE) |-> lb_reverse && !lb_pcs && !lb_analog)
    else $error("reverse loopback select wrong");

  chk_lb_other_off: assert property (
    (s.lb != pblc_pkg::LB_PCS) && (s.lb != pblc_pkg::LB_ANALOG)
      && (s.lb != pblc_pkg::LB_REVERSE) |-> !lb_pcs && !lb_analog && !lb_reverse)
    else $error("loopback select driven for normal or reserved code");

  chk_line_forward: assert property (
    s.lb_pcs && s.line_tx_ok && !gen_busy(s.gst)
      |=> (line_tx_en == $past(mac_tx_en)) && (line_txd == $past(mac_txd)))
    else $error("line transmit not forwarded in MII loopback");

  chk_line_ok_kept: assert property (
    psel && penable && pready && !pslverr && pwrite && pwdata[pblc_pkg::LINE_TX_BIT]
      && (pwdata[pblc_pkg::LB_LSB +: 4] == pblc_pkg::LB_PCS) |=> s.line_tx_ok)
    else $error("line transmit bit not kept in MII loopback");

  chk_gen_en_set: assert property (
    psel && penable && pready && !pslverr && pwrite && pwdata[pblc_pkg::GEN_EN_BIT]
      |=> s.gen_en)
    else $error("generator enable write not stored");

  chk_gen_en_clear: assert property (
    psel && penable && pready && !pslverr && pwrite && !pwdata[pblc_pkg::GEN_EN_BIT]
      |=> !s.gen_en)
    else $error("generator disable write not stored");

  chk_gen_start: assert property (
    s.gen_en && (s.gst == pblc_pkg::G_IDLE) |=> s.gst == pblc_pkg::G_DATA)
    else $error("enabled generator did not start");

  chk_pkt_end: assert property (
    s.gen_en && (s.gst == pblc_pkg::G_DATA)
      && (s.gcnt == 8'(pblc_pkg::PKT_NIB - 8'h01)) |=> s.gst == pblc_pkg::G_GAP)
    else $error("packet did not end at its length");

  chk_prbs_payload: assert property (
    s.pkt_type && (s.gst == pblc_pkg::G_DATA) |=> line_tx_en && (line_txd == s.lfsr[3:0]))
    else $error("PRBS nibble not sent");

  chk_const_payload: assert property (
    !s.pkt_type && (s.gst == pblc_pkg::G_DATA)
      |=> line_tx_en && (line_txd == pblc_pkg::CONST_NIB))
    else $error("constant nibble not sent");

  chk_gap_silent: assert property (
    (s.gst == pblc_pkg::G_GAP) |=> !line_tx_en)
    else $error("line transmit during packet gap");

  chk_single_done: assert property (
    s.gen_en && !s.pkt_type && (s.gst == pblc_pkg::G_GAP)
      && (s.gcnt == 8'(pblc_pkg::GAP_NIB - 8'h01)) |=> s.gst == pblc_pkg::G_DONE)
    else $error("single packet mode did not stop");

  chk_type0_unlock: assert property (
    !s.pkt_type |=> !chk_locked)
    else $error("checker locked with constant packet type");

  chk_loss_hold: assert property (
    s.sync_loss && !(psel && penable && pready && !pwrite) |=> s.sync_loss)
    else $error("sync loss dropped without a read");

  chk_bad_wr_ignored: assert property (
    pslverr |=> $stable(s.lb) && $stable(s.gen_en) && $stable(s.pkt_type))
    else $error("unmapped write changed the register");

  chk_prdata_idle: assert property (
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data outside the access cycle");

endmodule
`default_nettype wire

// [tb_prbs_bist_loopback_control.sv]
// Self-checking testbench for the PRBS self-test and loopback control block
`timescale 1ns/1ps
`default_nettype none

module tb_prbs_bist_loopback_control;
  localparam logic [11:0] REG_ADDR = {pblc_pkg::REG_IDX, 2'h0};
  localparam logic [11:0] BAD_ADDR = 12'h05C;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] mac_txd = 4'h0;
  logic mac_tx_en = 1'b0;
  logic [3:0] line_rxd = 4'h0;
  logic line_rx_dv = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] line_txd;
  logic line_tx_en;
  logic lb_pcs;
  logic lb_analog;
  logic lb_reverse;
  logic err_wrap;
  logic [7:0] err_count;
  logic [31:0] rd;
  logic se;
  int err_total = 0;
  int n_checks = 0;
  int cmode = 0;
  int nib = 0;

  always #25 pclk = ~pclk;

  pblc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mac_txd(mac_txd), .mac_tx_en(mac_tx_en), .line_txd(line_txd),
    .line_tx_en(line_tx_en), .line_rxd(line_rxd), .line_rx_dv(line_rx_dv),
    .lb_pcs(lb_pcs), .lb_analog(lb_analog), .lb_reverse(lb_reverse),
    .err_wrap(err_wrap), .err_count(err_count));

  // Line output looped back to the checker; sparse corruption keeps lock alive
  always @(posedge pclk) begin
    if (line_tx_en === 1'b1) nib <= nib + 1;
    line_rxd <= (cmode == 2 || (cmode == 1 && nib % 8 == 0)) ? ~line_txd : line_txd;
    line_rx_dv <= line_tx_en;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timeout(input string what);
    err_total++;
    $display("CHECK FAILED %s expected event seen timeout", what);
    summarize();
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) timeout("pready");
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_tx(input logic lvl, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      if (line_tx_en === lvl) break;
      @(posedge pclk);
    end
    if (k == lim) timeout("line_tx_en");
  endtask

  task automatic t_reset_and_map();
    apb(1'b0, REG_ADDR, 32'h0);
    chk("reset word", 32'h00000100, rd);
    chk("reset slverr", 32'h0, {31'h0, se});
    apb(1'b1, BAD_ADDR, 32'h00001000);
    chk("unmapped slverr", 32'h1, {31'h0, se});
    apb(1'b0, BAD_ADDR, 32'h0);
    chk("unmapped data", 32'h0, rd);
    repeat (5) @(posedge pclk);
    chk("ignored enable", 32'h0, {31'h0, line_tx_en});
  endtask

  task automatic t_loopback();
    logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
    logic [3:0] c;
    mac_txd <= 4'hA;
    mac_tx_en <= 1'b1;
    foreach (codes[i]) begin
      c = codes[i];
      apb(1'b1, REG_ADDR, {16'h0, 9'h000, 1'b1, c, 2'h3});
      apb(1'b0, REG_ADDR, 32'h0);
      chk("loopback word", {16'h0, 9'h002, c == 4'h1, c, 2'h3}, rd);
      repeat (3) @(posedge pclk);
      chk("loop selects", {29'h0, c == 4'h4, c == 4'h2, c == 4'h1},
          {29'h0, lb_reverse, lb_analog, lb_pcs});
      if (c == 4'h1) chk("forward", 32'h1A, {27'h0, line_tx_en, line_txd});
    end
    apb(1'b1, REG_ADDR, 32'h00000004);
    repeat (3) @(posedge pclk);
    chk("suppress", 32'h0, {27'h0, line_tx_en, line_txd});
    mac_tx_en <= 1'b0;
    mac_txd <= 4'h0;
    apb(1'b1, REG_ADDR, 32'h0);
  endtask

  task automatic t_single_packet();
    int n;
    int bad;
    bad = 0;
    apb(1'b1, REG_ADDR, 32'h00001000);
    wait_tx(1'b1, 20);
    for (n = 0; n < 64 && line_tx_en === 1'b1; n++) begin
      if (line_txd !== pblc_pkg::CONST_NIB) bad++;
      @(posedge pclk);
    end
    chk("const length", 32'h40, n);
    chk("const nibbles", 32'h0, bad);
    n = 0;
    repeat (300) begin
      if (line_tx_en === 1'b1) n++;
      @(posedge pclk);
    end
    chk("only one packet", 32'h0, n);
    apb(1'b0, REG_ADDR, 32'h0);
    chk("checker idle", 32'h0, {22'h0, rd[11:10], err_count});
    apb(1'b1, REG_ADDR, 32'h0);
  endtask

  task automatic t_prbs_stream();
    int n;
    apb(1'b1, REG_ADDR, 32'h00003000);
    wait_tx(1'b1, 20);
    for (n = 0; n < 100 && line_tx_en === 1'b1; n++) @(posedge pclk);
    chk("prbs length", 32'h40, n);
    for (n = 0; n < 100 && line_tx_en === 1'b0; n++) @(posedge pclk);
    chk("prbs gap", 32'h18, n);
    repeat (200) @(posedge pclk);
    apb(1'b0, REG_ADDR, 32'h0);
    chk("gen and lock", 32'h3, {30'h0, rd[11], rd[9]});
    wait_tx(1'b0, 100);
    wait_tx(1'b1, 100);
    cmode <= 2;
    repeat (8) @(posedge pclk);
    cmode <= 0;
    repeat (10) @(posedge pclk);
    apb(1'b0, REG_ADDR, 32'h0);
    chk("loss latched", 32'h1, {31'h0, rd[10]});
    apb(1'b0, REG_ADDR, 32'h0);
    chk("loss cleared", 32'h0, {31'h0, rd[10]});
  endtask

  task automatic t_err_counter();
    int k;
    int w;
    w = 0;
    cmode <= 1;
    for (k = 0; k < 20000 && err_count !== 8'hFF; k++) @(posedge pclk);
    if (k == 20000) timeout("err_count");
    repeat (500) begin
      @(posedge pclk);
      if (err_wrap === 1'b1) w++;
    end
    chk("single hold", 32'hFF, {24'h0, err_count});
    chk("single no wrap", 32'h0, w);
    apb(1'b1, REG_ADDR, 32'h00007000);
    for (k = 0; k < 20000 && err_wrap !== 1'b1; k++) @(posedge pclk);
    if (k == 20000) timeout("err_wrap");
    chk("wrap to zero", 32'h0, {24'h0, err_count});
    cmode <= 0;
  endtask

  task automatic t_checker_without_gen();
    repeat (400) @(posedge pclk);
    apb(1'b1, REG_ADDR, 32'h00002000);
    repeat (4) @(posedge pclk);
    chk("gen stopped", 32'h0, {31'h0, line_tx_en});
    apb(1'b0, REG_ADDR, 32'h0);
    chk("checker kept", 32'h2, {30'h0, rd[11], rd[9]});
    apb(1'b1, REG_ADDR, 32'h0);
    apb(1'b0, REG_ADDR, 32'h0);
    chk("checker off", 32'h0, {31'h0, rd[11]});
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_and_map();
    t_loopback();
    t_single_packet();
    t_prbs_stream();
    t_err_counter();
    t_checker_without_gen();
    summarize();
  end
endmodule

`default_nettype wire
